// ===== design/status_flag_bit_ops_cfg.svh
// Constants for the status-flag and bit-manipulation execution block.
`ifndef STATUS_FLAG_BIT_OPS_CFG_SVH
`define STATUS_FLAG_BIT_OPS_CFG_SVH
`define FLAG_POS_C        3'h0
`define FLAG_POS_Z        3'h1
`define FLAG_POS_N        3'h2
`define FLAG_POS_V        3'h3
`define FLAG_POS_S        3'h4
`define FLAG_POS_H        3'h5
`define FLAG_POS_T        3'h6
`define FLAG_POS_I        3'h7
`define FLAGS_RESET_VAL   8'h00
`define REG_RESET_VAL     8'h00
`define REG_COUNT         32
`endif

// ===== design/status_flag_bit_ops_pkg.sv
// Types for the status-flag and bit-manipulation execution block.
`default_nettype none
package status_flag_bit_ops_pkg;
    typedef enum logic [4:0] {
        op_none_type_v               = 5'h00,
        nibble_swap_op               = 5'h01,
        indexed_flag_set_op          = 5'h02,
        indexed_flag_clear_op        = 5'h03,
        bit_to_transfer_flag_op      = 5'h04,
        transfer_flag_to_bit_op      = 5'h05,
        carry_set_op                 = 5'h06,
        carry_clear_op               = 5'h07,
        negative_set_op              = 5'h08,
        negative_clear_op            = 5'h09,
        zero_set_op                  = 5'h0a,
        zero_clear_op                = 5'h0b,
        int_enable_set_op            = 5'h0c,
        int_enable_clear_op          = 5'h0d,
        sign_test_set_op             = 5'h0e,
        sign_test_clear_op           = 5'h0f,
        overflow_set_op              = 5'h10,
        overflow_clear_op            = 5'h11,
        transfer_set_op              = 5'h12,
        transfer_clear_op            = 5'h13,
        half_carry_set_op            = 5'h14,
        half_carry_clear_op          = 5'h15
    } op_code_type;

    typedef struct packed {
        logic        valid;
        op_code_type op;
        logic [4:0]  reg_sel;
        logic [2:0]  bit_sel;
    } instr_type;

    typedef struct packed {
        logic        wr_en;
        logic [4:0]  wr_sel;
        logic [7:0]  wr_data;
    } reg_write_type;
endpackage
`default_nettype wire

// ===== design/flag_update_unit.sv
// Combinational next value of the status flags for one instruction.
`timescale 1ns/100ps
`default_nettype none
`include "status_flag_bit_ops_cfg.svh"
module flag_update_unit
(
    input  wire logic [7:0]                       flags,
    input  wire status_flag_bit_ops_pkg::instr_type instr,
    input  wire logic [7:0]                       src_data,
    output logic      [7:0]                       nxt_flags
);
    import status_flag_bit_ops_pkg::*;

    always_comb
    begin
        nxt_flags = flags;
        if (instr.valid)
        begin
            case (instr.op)
                indexed_flag_set_op:     nxt_flags[instr.bit_sel] = 1'b1;
                indexed_flag_clear_op:   nxt_flags[instr.bit_sel] = 1'b0;
                bit_to_transfer_flag_op:
                    nxt_flags[`FLAG_POS_T] = src_data[instr.bit_sel];
                half_carry_set_op:       nxt_flags[`FLAG_POS_H] = 1'b1;
                half_carry_clear_op:     nxt_flags[`FLAG_POS_H] = 1'b0;
                overflow_set_op:         nxt_flags[`FLAG_POS_V] = 1'b1;
                overflow_clear_op:       nxt_flags[`FLAG_POS_V] = 1'b0;
                sign_test_set_op:        nxt_flags[`FLAG_POS_S] = 1'b1;
                sign_test_clear_op:      nxt_flags[`FLAG_POS_S] = 1'b0;
                carry_set_op:            nxt_flags[`FLAG_POS_C] = 1'b1;
                carry_clear_op:          nxt_flags[`FLAG_POS_C] = 1'b0;
                negative_set_op:         nxt_flags[`FLAG_POS_N] = 1'b1;
                negative_clear_op:       nxt_flags[`FLAG_POS_N] = 1'b0;
                zero_set_op:             nxt_flags[`FLAG_POS_Z] = 1'b1;
                zero_clear_op:           nxt_flags[`FLAG_POS_Z] = 1'b0;
                int_enable_set_op:       nxt_flags[`FLAG_POS_I] = 1'b1;
                int_enable_clear_op:     nxt_flags[`FLAG_POS_I] = 1'b0;
                transfer_set_op:         nxt_flags[`FLAG_POS_T] = 1'b1;
                transfer_clear_op:       nxt_flags[`FLAG_POS_T] = 1'b0;
                default:                 nxt_flags = flags;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== design/status_flag_bit_ops.sv
// Execution of nibble swap, status-flag and bit-transfer instructions.
//
// Overview of operation
// - Swap exchanges register nibbles in one cycle, flags unchanged.
// - Indexed set or clear forces only the chosen status bit, one cycle.
// - Bit store copies the chosen register bit into the transfer flag.
// - Bit load copies the transfer flag into the chosen register bit.
// - Dedicated ops set or clear half carry only, one cycle.
// - Dedicated ops set or clear overflow only, one cycle.
// - Dedicated ops set or clear signed test only, one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "status_flag_bit_ops_cfg.svh"
module status_flag_bit_ops
(
    input  wire logic                               ref_clk,
    input  wire logic                               sys_rst,
    input  wire status_flag_bit_ops_pkg::instr_type instr,
    output logic      [7:0]                         status_flags_reg,
    output var  status_flag_bit_ops_pkg::reg_write_type reg_wr,
    output logic      [`REG_COUNT*8-1:0]            reg_file_out
);
    import status_flag_bit_ops_pkg::*;

    logic [7:0]    regs_ff [`REG_COUNT];
    logic [7:0]    flags_ff;
    logic [7:0]    nxt_flags;
    logic [7:0]    src_data;
    reg_write_type nxt_reg_wr;
    reg_write_type reg_wr_ff;
    logic [2:0]    touch_pos;
    logic          touch_any;
    logic [7:0]    flag_touch;
    logic [7:0]    gated_flags;

    assign src_data = regs_ff[instr.reg_sel];

    flag_update_unit u_flag_update
    (
        .flags     (flags_ff),
        .instr     (instr),
        .src_data  (src_data),
        .nxt_flags (nxt_flags)
    );

    always_comb
    begin
        nxt_reg_wr = '0;
        nxt_reg_wr.wr_sel = instr.reg_sel;
        nxt_reg_wr.wr_data = src_data;
        if (instr.valid)
        begin
            case (instr.op)
                nibble_swap_op:
                begin
                    nxt_reg_wr.wr_en = 1'b1;
                    nxt_reg_wr.wr_data = {src_data[3:0], src_data[7:4]};
                end
                transfer_flag_to_bit_op:
                begin
                    nxt_reg_wr.wr_en = 1'b1;
                    nxt_reg_wr.wr_data[instr.bit_sel] = flags_ff[`FLAG_POS_T];
                end
                default:
                begin
                    nxt_reg_wr.wr_en = 1'b0;
                end
            endcase
        end
    end

    // Only the flag that the instruction names may move; every other bit holds.
    always_comb
    begin
        touch_pos = 3'h0;
        touch_any = 1'b0;
        if (instr.valid)
        begin
            case (instr.op)
                indexed_flag_set_op:
                begin
                    touch_pos = instr.bit_sel;
                    touch_any = 1'b1;
                end
                indexed_flag_clear_op:
                begin
                    touch_pos = instr.bit_sel;
                    touch_any = 1'b1;
                end
                bit_to_transfer_flag_op:
                begin
                    touch_pos = `FLAG_POS_T;
                    touch_any = 1'b1;
                end
                half_carry_set_op:
                begin
                    touch_pos = `FLAG_POS_H;
                    touch_any = 1'b1;
                end
                half_carry_clear_op:
                begin
                    touch_pos = `FLAG_POS_H;
                    touch_any = 1'b1;
                end
                overflow_set_op:
                begin
                    touch_pos = `FLAG_POS_V;
                    touch_any = 1'b1;
                end
                overflow_clear_op:
                begin
                    touch_pos = `FLAG_POS_V;
                    touch_any = 1'b1;
                end
                sign_test_set_op:
                begin
                    touch_pos = `FLAG_POS_S;
                    touch_any = 1'b1;
                end
                sign_test_clear_op:
                begin
                    touch_pos = `FLAG_POS_S;
                    touch_any = 1'b1;
                end
                carry_set_op:
                begin
                    touch_pos = `FLAG_POS_C;
                    touch_any = 1'b1;
                end
                carry_clear_op:
                begin
                    touch_pos = `FLAG_POS_C;
                    touch_any = 1'b1;
                end
                negative_set_op:
                begin
                    touch_pos = `FLAG_POS_N;
                    touch_any = 1'b1;
                end
                negative_clear_op:
                begin
                    touch_pos = `FLAG_POS_N;
                    touch_any = 1'b1;
                end
                zero_set_op:
                begin
                    touch_pos = `FLAG_POS_Z;
                    touch_any = 1'b1;
                end
                zero_clear_op:
                begin
                    touch_pos = `FLAG_POS_Z;
                    touch_any = 1'b1;
                end
                int_enable_set_op:
                begin
                    touch_pos = `FLAG_POS_I;
                    touch_any = 1'b1;
                end
                int_enable_clear_op:
                begin
                    touch_pos = `FLAG_POS_I;
                    touch_any = 1'b1;
                end
                transfer_set_op:
                begin
                    touch_pos = `FLAG_POS_T;
                    touch_any = 1'b1;
                end
                transfer_clear_op:
                begin
                    touch_pos = `FLAG_POS_T;
                    touch_any = 1'b1;
                end
                default:
                begin
                    touch_pos = 3'h0;
                    touch_any = 1'b0;
                end
            endcase
        end
    end

    genvar gf;
    generate
        for (gf = 0; gf < 8; gf++)
        begin : g_flag
            assign flag_touch[gf] = touch_any && (touch_pos == 3'(gf));
            assign gated_flags[gf] = flag_touch[gf] ? nxt_flags[gf] : flags_ff[gf];
        end
    endgenerate

    // Flags only move through the flag unit; swap and bit load leave them alone.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            flags_ff <= `FLAGS_RESET_VAL;
        else
            flags_ff <= gated_flags;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `REG_COUNT; gi++)
        begin : g_reg
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                    regs_ff[gi] <= `REG_RESET_VAL;
                else if (nxt_reg_wr.wr_en && (nxt_reg_wr.wr_sel == 5'(gi)))
                    regs_ff[gi] <= nxt_reg_wr.wr_data;
            end
            assign reg_file_out[gi*8 +: 8] = regs_ff[gi];
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            reg_wr_ff <= '0;
        else
            reg_wr_ff <= nxt_reg_wr;
    end

    assign status_flags_reg = flags_ff;
    assign reg_wr = reg_wr_ff;
endmodule
`default_nettype wire

// ===== verification/status_flag_bit_ops_sva.sv
// Property checker for the status-flag and bit-manipulation block.
`timescale 1ns/100ps
`default_nettype none
`include "status_flag_bit_ops_cfg.svh"
module status_flag_bit_ops_sva
(
    input wire logic                                   ref_clk,
    input wire logic                                   sys_rst,
    input wire status_flag_bit_ops_pkg::instr_type     instr,
    input wire logic [7:0]                             status_flags_reg,
    input wire status_flag_bit_ops_pkg::reg_write_type reg_wr,
    input wire logic [`REG_COUNT*8-1:0]                reg_file_out
);
    import status_flag_bit_ops_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence take(op_code_type o);
        instr.valid && instr.op == o;
    endsequence
    nibble_swap_a: assert property (take(nibble_swap_op) |=>
        $stable(status_flags_reg) && reg_wr.wr_en && reg_wr.wr_data ==
        {$past(reg_file_out[{instr.reg_sel, 3'h0} +: 4]),
        $past(reg_file_out[{instr.reg_sel, 3'h4} +: 4])}) else $error("swap");
    index_set_a: assert property (take(indexed_flag_set_op) |=>
        status_flags_reg == ($past(status_flags_reg) | (8'h01 << $past(instr.bit_sel))))
        else $error("index set");
    index_clear_a: assert property (take(indexed_flag_clear_op) |=>
        status_flags_reg == ($past(status_flags_reg) & ~(8'h01 << $past(instr.bit_sel))))
        else $error("index clear");
    bit_store_a: assert property (take(bit_to_transfer_flag_op) |=>
        status_flags_reg == {$past(status_flags_reg[7]),
        $past(reg_file_out[{instr.reg_sel, instr.bit_sel}]), $past(status_flags_reg[5:0])})
        else $error("bit store");
    bit_load_a: assert property (take(transfer_flag_to_bit_op) |=>
        $stable(status_flags_reg) && reg_wr.wr_en && reg_wr.wr_sel == $past(instr.reg_sel) &&
        reg_wr.wr_data[$past(instr.bit_sel)] == status_flags_reg[6]) else $error("bit load");
    half_set_a: assert property (take(half_carry_set_op) |=>
        status_flags_reg == ($past(status_flags_reg) | 8'h20)) else $error("half set");
    over_clear_a: assert property (take(overflow_clear_op) |=>
        status_flags_reg == ($past(status_flags_reg) & 8'hf7)) else $error("over clear");
    sign_set_a: assert property (take(sign_test_set_op) |=>
        status_flags_reg == ($past(status_flags_reg) | 8'h10)) else $error("sign set");
endmodule
bind status_flag_bit_ops status_flag_bit_ops_sva checker_i
    (.ref_clk, .sys_rst, .instr, .status_flags_reg, .reg_wr, .reg_file_out);
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the status-flag and bit-manipulation block.
`timescale 1ns/100ps
`default_nettype none
`include "status_flag_bit_ops_cfg.svh"
module testbench;
    import status_flag_bit_ops_pkg::*;
    typedef struct packed {op_code_type op; logic [4:0] r; logic [2:0] b;
        logic [7:0] f; logic [7:0] d;} row_type;
    row_type rows [24] = '{
        '{carry_set_op,            5'h03, 3'h0, 8'h01, 8'h00},
        '{zero_set_op,             5'h03, 3'h0, 8'h03, 8'h00},
        '{negative_set_op,         5'h03, 3'h0, 8'h07, 8'h00},
        '{overflow_set_op,         5'h03, 3'h0, 8'h0f, 8'h00},
        '{sign_test_set_op,        5'h03, 3'h0, 8'h1f, 8'h00},
        '{half_carry_set_op,       5'h03, 3'h0, 8'h3f, 8'h00},
        '{transfer_set_op,         5'h03, 3'h0, 8'h7f, 8'h00},
        '{int_enable_set_op,       5'h03, 3'h0, 8'hff, 8'h00},
        '{transfer_flag_to_bit_op, 5'h03, 3'h5, 8'hff, 8'h20},
        '{nibble_swap_op,          5'h03, 3'h0, 8'hff, 8'h02},
        '{transfer_flag_to_bit_op, 5'h03, 3'h7, 8'hff, 8'h82},
        '{carry_clear_op,          5'h03, 3'h0, 8'hfe, 8'h82},
        '{zero_clear_op,           5'h03, 3'h0, 8'hfc, 8'h82},
        '{negative_clear_op,       5'h03, 3'h0, 8'hf8, 8'h82},
        '{overflow_clear_op,       5'h03, 3'h0, 8'hf0, 8'h82},
        '{sign_test_clear_op,      5'h03, 3'h0, 8'he0, 8'h82},
        '{half_carry_clear_op,     5'h03, 3'h0, 8'hc0, 8'h82},
        '{int_enable_clear_op,     5'h03, 3'h0, 8'h40, 8'h82},
        '{transfer_clear_op,       5'h03, 3'h0, 8'h00, 8'h82},
        '{bit_to_transfer_flag_op, 5'h03, 3'h1, 8'h40, 8'h82},
        '{indexed_flag_set_op,     5'h03, 3'h7, 8'hc0, 8'h82},
        '{indexed_flag_clear_op,   5'h03, 3'h6, 8'h80, 8'h82},
        '{indexed_flag_set_op,     5'h03, 3'h6, 8'hc0, 8'h82},
        '{transfer_flag_to_bit_op, 5'h1f, 3'h0, 8'hc0, 8'h01}};
    logic                    ref_clk = 1'b0;
    logic                    sys_rst = 1'b1;
    instr_type               instr = '0;
    logic [7:0]              status_flags_reg;
    reg_write_type           reg_wr;
    logic [`REG_COUNT*8-1:0] reg_file_out;
    int                      errors = 0;
    int                      comparisons = 0;
    status_flag_bit_ops DUT (.ref_clk, .sys_rst, .instr,
        .status_flags_reg, .reg_wr, .reg_file_out);
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task stop_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    initial
    begin
        #(40 * 200);
        errors++;
        stop_test;
    end
    initial
    begin
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk("flags", status_flags_reg, 8'h00);
        foreach (rows[i])
        begin
            instr = {1'b1, rows[i].op, rows[i].r, rows[i].b};
            @(negedge ref_clk);
            chk("flags", status_flags_reg, rows[i].f);
            chk("reg", reg_file_out[{rows[i].r, 3'h0} +: 8], rows[i].d);
        end
        chk("wr sel", {3'h0, reg_wr.wr_sel}, 8'h1f);
        chk("wr data", reg_wr.wr_data, 8'h01);
        chk("wr en", {7'h00, reg_wr.wr_en}, 8'h01);
        chk("reg0", reg_file_out[7:0], 8'h00);
        instr = {1'b0, int_enable_clear_op, 5'h03, 3'h0};
        @(negedge ref_clk);
        chk("wr en", {7'h00, reg_wr.wr_en}, 8'h00);
        chk("flags", status_flags_reg, 8'hc0);
        instr = {1'b1, 5'h16, 5'h03, 3'h0};
        @(negedge ref_clk);
        chk("flags", status_flags_reg, 8'hc0);
        sys_rst = 1'b1;
        @(negedge ref_clk);
        chk("flags", status_flags_reg, 8'h00);
        chk("reg", reg_file_out[31:24], 8'h00);
        stop_test;
    end
endmodule
`default_nettype wire
